// [inc/lcom_pkg.sv]
// Instance map, field positions and constants of the load command object map
package lcom_pkg;
   localparam int unsigned INST_W = 16;
   localparam int unsigned DATA_W = 32;

   // Service instances
   localparam logic [15:0] INST_STATUS1      = 16'h000E;
   localparam logic [15:0] INST_INPUT_EN     = 16'h0011;
   localparam logic [15:0] INST_MEAS_CURR    = 16'h0101;
   localparam logic [15:0] INST_MEAS_VOLT    = 16'h0102;
   localparam logic [15:0] INST_MEAS_PWR     = 16'h0103;
   localparam logic [15:0] INST_MEAS_RES     = 16'h0104;
   localparam logic [15:0] INST_CURR_TGT_WR  = 16'h0201;
   localparam logic [15:0] INST_CURR_TGT_RD  = 16'h0202;
   localparam logic [15:0] INST_VOLT_TGT_WR  = 16'h0203;
   localparam logic [15:0] INST_VOLT_TGT_RD  = 16'h0204;
   localparam logic [15:0] INST_PWR_TGT_WR   = 16'h0205;
   localparam logic [15:0] INST_PWR_TGT_RD   = 16'h0206;
   localparam logic [15:0] INST_RES_TGT_WR   = 16'h0207;
   localparam logic [15:0] INST_RES_TGT_RD   = 16'h0208;
   localparam logic [15:0] INST_CURR_TRIP_WR = 16'h0301;
   localparam logic [15:0] INST_CURR_TRIP_RD = 16'h0302;
   localparam logic [15:0] INST_HV_TRIP_WR   = 16'h0303;
   localparam logic [15:0] INST_HV_TRIP_RD   = 16'h0304;
   localparam logic [15:0] INST_PWR_TRIP_WR  = 16'h0305;
   localparam logic [15:0] INST_PWR_TRIP_RD  = 16'h0306;
   localparam logic [15:0] INST_LV_TRIP_WR   = 16'h0307;
   localparam logic [15:0] INST_LV_TRIP_RD   = 16'h0308;

   // Second status word bit positions
   localparam int unsigned ST_MISSING_PHASE  = 0;
   localparam int unsigned ST_FUSE_OPEN      = 1;
   localparam int unsigned ST_FAN_STALL      = 2;
   localparam int unsigned ST_PWR_MOD_HOT    = 4;
   localparam int unsigned ST_FILTER_HOT     = 5;
   localparam int unsigned ST_CAP_HOT        = 6;
   localparam int unsigned ST_XFMR_HOT       = 7;
   localparam int unsigned ST_BAD_RATING     = 16;
   localparam int unsigned ST_FW_MISMATCH    = 17;

   // Trip fault vector positions
   localparam int unsigned TRIP_CURR = 0;
   localparam int unsigned TRIP_HV   = 1;
   localparam int unsigned TRIP_PWR  = 2;
   localparam int unsigned TRIP_LV   = 3;
   localparam int unsigned TRIP_N    = 4;

   // Consecutive over-limit samples needed to trip
   localparam logic [2:0]  TRIP_SAMPLES = 3'h4;

   // Reset values
   localparam logic [31:0] FLOAT_ZERO_RST = 32'h0000_0000;
   localparam logic        INPUT_EN_RST   = 1'b0;

   // Measurement selectors
   localparam logic [1:0] MSEL_CURR = 2'h0;
   localparam logic [1:0] MSEL_VOLT = 2'h1;
   localparam logic [1:0] MSEL_PWR  = 2'h2;
   localparam logic [1:0] MSEL_RES  = 2'h3;

   typedef enum logic [0:0] {
      LCOM_IDLE = 1'b0,
      LCOM_MEAS = 1'b1
   } lcom_state_t;
endpackage : lcom_pkg

// [rtl/lcom_core.sv]
// Command-object register bank with live status and trip monitor
`timescale 1ns/100ps
`default_nettype none
module lcom_core
   import lcom_pkg::*;
(
   input  wire logic        i_ref_clk,           // 200 MHz clock
   input  wire logic        i_sys_rst,           // Async reset, high
   // Service port
   input  wire logic        i_svc_valid,         // Request strobe
   input  wire logic        i_svc_set,           // 1 Set, 0 Get
   input  wire logic [15:0] i_svc_inst,          // Instance number
   input  wire logic [31:0] i_svc_wdata,         // Set value
   output logic             o_svc_done,          // Answer strobe
   output logic             o_svc_err,           // Answer is refusal
   output logic [31:0]      o_svc_rdata,         // Get value
   output logic             o_svc_busy,          // Query pending
   // Measurement front end, same clock
   input  wire logic        i_meas_valid,        // New averaged sample
   input  wire logic [31:0] i_meas_current,      // Avg current float
   input  wire logic [31:0] i_meas_voltage,      // Avg terminal volts
   input  wire logic [31:0] i_meas_sense_volt,   // Avg sense volts
   input  wire logic        i_sense_engaged,     // Remote sense in use
   input  wire logic [31:0] i_meas_power,        // Avg power float
   input  wire logic [31:0] i_meas_resistance,   // Avg resistance
   // Fault pins, asynchronous
   input  wire logic        i_missing_phase_flag,      // Phase lost
   input  wire logic        i_input_fuse_open_flag,    // Fuse blown
   input  wire logic        i_fan_stall_flag,          // Fan locked
   input  wire logic        i_power_module_overheat,   // Hot module
   input  wire logic        i_output_filter_overheat,  // Hot filter
   input  wire logic        i_output_capacitor_overheat, // Hot caps
   input  wire logic        i_transformer_overheat,    // Hot xfmr
   input  wire logic        i_bad_rating_flag,         // Bad rating
   input  wire logic        i_firmware_mismatch_flag,  // FW conflict
   // Load control
   output logic             o_input_on,          // Input connected
   output logic             o_term_hiz,          // Terminals high-Z
   output logic [31:0]      o_current_target,    // CC target
   output logic [31:0]      o_voltage_target,    // CV target
   output logic [31:0]      o_power_target,      // CP target
   output logic [31:0]      o_resistance_target, // CR target
   output logic [3:0]       o_trip_fault         // Trip faults
);
   import lcom_pkg::*;

   // IEEE single compare a > b; both zeros compare equal
   // NaN is not expected from the front end; it orders by bit pattern
   function automatic logic fp_gt(input logic [31:0] a,
                                  input logic [31:0] b);
      logic az;
      logic bz;
      az = (a[30:0] == 31'h0000_0000);
      bz = (b[30:0] == 31'h0000_0000);
      if (az && bz) begin
         fp_gt = 1'b0;
      end else if (a[31] != b[31]) begin
         fp_gt = ~a[31];
      end else if (!a[31]) begin
         fp_gt = a[30:0] > b[30:0];
      end else begin
         fp_gt = a[30:0] < b[30:0];
      end
   endfunction : fp_gt

   lcom_state_t state_reg;
   lcom_state_t state_next;

   logic [31:0] curr_tgt_reg;
   logic [31:0] volt_tgt_reg;
   logic [31:0] pwr_tgt_reg;
   logic [31:0] res_tgt_reg;
   logic [31:0] curr_trip_reg;
   logic [31:0] hv_trip_reg;
   logic [31:0] pwr_trip_reg;
   logic [31:0] lv_trip_reg;
   logic        input_en_reg;
   logic        input_en_next;
   logic [3:0]  fault_reg;
   logic [3:0]  fault_next;
   logic [2:0]  trip_cnt_reg [TRIP_N];
   logic [1:0]  msel_reg;
   logic        done_reg;
   logic        err_reg;
   logic [31:0] rdata_reg;
   logic        busy_reg;
   logic        hiz_reg;
   logic [8:0]  pin_meta_reg;
   logic [8:0]  pin_sync_reg;

   // Fault pins pass two flops before any use
   wire [8:0] pin_raw = {i_firmware_mismatch_flag,
                         i_bad_rating_flag,
                         i_transformer_overheat,
                         i_output_capacitor_overheat,
                         i_output_filter_overheat,
                         i_power_module_overheat,
                         i_fan_stall_flag,
                         i_input_fuse_open_flag,
                         i_missing_phase_flag};

   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         pin_meta_reg <= 9'h000;
         pin_sync_reg <= 9'h000;
      end else begin
         pin_meta_reg <= pin_raw;
         pin_sync_reg <= pin_meta_reg;
      end
   end

   // Live, unlatched status; other bits tied to zero
   wire [31:0] status_word = {
      14'h0000,
      pin_sync_reg[8],
      pin_sync_reg[7],
      8'h00,
      pin_sync_reg[6:3],
      1'b0,
      pin_sync_reg[2],
      pin_sync_reg[1],
      pin_sync_reg[0]};

   // Request decode
   wire take     = i_svc_valid && (state_reg == LCOM_IDLE);
   wire take_set = take && i_svc_set;
   wire take_get = take && !i_svc_set;
   wire inst_hi  = (i_svc_inst[15:8] == 8'h01);
   wire is_meas  = inst_hi && (i_svc_inst[7:0] >= 8'h01)
                   && (i_svc_inst[7:0] <= 8'h04);
   // Query instances one to four pick selectors zero to three
   wire [1:0] msel_new = 2'(i_svc_inst[1:0] - 2'h1);

   wire wr_en   = take_set && (i_svc_inst == INST_INPUT_EN);
   wire wr_ctgt = take_set && (i_svc_inst == INST_CURR_TGT_WR);
   wire wr_vtgt = take_set && (i_svc_inst == INST_VOLT_TGT_WR);
   wire wr_ptgt = take_set && (i_svc_inst == INST_PWR_TGT_WR);
   wire wr_rtgt = take_set && (i_svc_inst == INST_RES_TGT_WR);
   wire wr_ctrp = take_set && (i_svc_inst == INST_CURR_TRIP_WR);
   wire wr_htrp = take_set && (i_svc_inst == INST_HV_TRIP_WR);
   wire wr_ptrp = take_set && (i_svc_inst == INST_PWR_TRIP_WR);
   wire wr_ltrp = take_set && (i_svc_inst == INST_LV_TRIP_WR);
   wire set_ok  = wr_en | wr_ctgt | wr_vtgt | wr_ptgt | wr_rtgt
                  | wr_ctrp | wr_htrp | wr_ptrp | wr_ltrp;

   // Read-back mux for immediate Gets
   wire rd_st   = (i_svc_inst == INST_STATUS1);
   wire rd_ctgt = (i_svc_inst == INST_CURR_TGT_RD);
   wire rd_vtgt = (i_svc_inst == INST_VOLT_TGT_RD);
   wire rd_ptgt = (i_svc_inst == INST_PWR_TGT_RD);
   wire rd_rtgt = (i_svc_inst == INST_RES_TGT_RD);
   wire rd_ctrp = (i_svc_inst == INST_CURR_TRIP_RD);
   wire rd_htrp = (i_svc_inst == INST_HV_TRIP_RD);
   wire rd_ptrp = (i_svc_inst == INST_PWR_TRIP_RD);
   wire rd_ltrp = (i_svc_inst == INST_LV_TRIP_RD);
   wire get_ok  = rd_st | rd_ctgt | rd_vtgt | rd_ptgt | rd_rtgt
                  | rd_ctrp | rd_htrp | rd_ptrp | rd_ltrp;
   wire [31:0] get_data = rd_st   ? status_word   :
                          rd_ctgt ? curr_tgt_reg  :
                          rd_vtgt ? volt_tgt_reg  :
                          rd_ptgt ? pwr_tgt_reg   :
                          rd_rtgt ? res_tgt_reg   :
                          rd_ctrp ? curr_trip_reg :
                          rd_htrp ? hv_trip_reg   :
                          rd_ptrp ? pwr_trip_reg  :
                          rd_ltrp ? lv_trip_reg   :
                          FLOAT_ZERO_RST;

   // Measured value picked for a pending query
   wire [31:0] volt_view = i_sense_engaged ? i_meas_sense_volt
                                           : i_meas_voltage;
   wire [31:0] meas_data = (msel_reg == MSEL_CURR) ? i_meas_current :
                           (msel_reg == MSEL_VOLT) ? volt_view :
                           (msel_reg == MSEL_PWR)  ? i_meas_power :
                           i_meas_resistance;
   wire meas_done = (state_reg == LCOM_MEAS) && i_meas_valid;

   // Trip monitor: over-limit test per sample
   wire [3:0] over;
   assign over[TRIP_CURR] = fp_gt(i_meas_current, curr_trip_reg);
   assign over[TRIP_HV]   = fp_gt(i_meas_voltage, hv_trip_reg);
   assign over[TRIP_PWR]  = fp_gt(i_meas_power, pwr_trip_reg);
   assign over[TRIP_LV]   = fp_gt(lv_trip_reg, i_meas_voltage);

   // Counting only while connected stops the under-voltage check
   // tripping on a dead, disconnected input
   wire count_on = input_en_reg && i_meas_valid;
   wire [3:0] trip_now;
   // The fourth over-limit sample in a row trips the check
   genvar g;
   for (g = 0; g < TRIP_N; g++) begin : g_trip
      assign trip_now[g] = count_on && over[g]
                           && (trip_cnt_reg[g] == TRIP_SAMPLES - 3'h1);
   end
   wire any_trip = |trip_now;

   // Enable and fault flags: a trip wins over a re-enable
   always_comb begin
      input_en_next = input_en_reg;
      fault_next    = fault_reg | trip_now;
      if (wr_en) begin
         input_en_next = i_svc_wdata[0];
         if (i_svc_wdata[0]) begin
            fault_next = trip_now;
         end
      end
      if (any_trip) begin
         input_en_next = 1'b0;
      end
   end

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         LCOM_IDLE: begin
            if (take_get && is_meas) begin
               state_next = LCOM_MEAS;
            end
         end
         LCOM_MEAS: begin
            if (i_meas_valid) begin
               state_next = LCOM_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         for (int i = 0; i < TRIP_N; i++) begin
            trip_cnt_reg[i] <= 3'h0;
         end
      end else begin
         for (int i = 0; i < TRIP_N; i++) begin
            if (!input_en_reg || any_trip) begin
               trip_cnt_reg[i] <= 3'h0;
            end else if (i_meas_valid) begin
               trip_cnt_reg[i] <= over[i] ? 3'(trip_cnt_reg[i] + 3'h1)
                                          : 3'h0;
            end
         end
      end
   end

   // One 32-bit register per target and trip value, shared by its Set and Get instances
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         curr_tgt_reg  <= FLOAT_ZERO_RST;
         volt_tgt_reg  <= FLOAT_ZERO_RST;
         pwr_tgt_reg   <= FLOAT_ZERO_RST;
         res_tgt_reg   <= FLOAT_ZERO_RST;
         curr_trip_reg <= FLOAT_ZERO_RST;
         hv_trip_reg   <= FLOAT_ZERO_RST;
         pwr_trip_reg  <= FLOAT_ZERO_RST;
         lv_trip_reg   <= FLOAT_ZERO_RST;
      end else begin
         if (wr_ctgt) begin
            curr_tgt_reg <= i_svc_wdata;
         end
         if (wr_vtgt) begin
            volt_tgt_reg <= i_svc_wdata;
         end
         if (wr_ptgt) begin
            pwr_tgt_reg <= i_svc_wdata;
         end
         if (wr_rtgt) begin
            res_tgt_reg <= i_svc_wdata;
         end
         if (wr_ctrp) begin
            curr_trip_reg <= i_svc_wdata;
         end
         if (wr_htrp) begin
            hv_trip_reg <= i_svc_wdata;
         end
         if (wr_ptrp) begin
            pwr_trip_reg <= i_svc_wdata;
         end
         if (wr_ltrp) begin
            lv_trip_reg <= i_svc_wdata;
         end
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state_reg    <= LCOM_IDLE;
         input_en_reg <= INPUT_EN_RST;
         hiz_reg      <= 1'b1;
         fault_reg    <= 4'h0;
         msel_reg     <= MSEL_CURR;
         busy_reg     <= 1'b0;
      end else begin
         state_reg    <= state_next;
         input_en_reg <= input_en_next;
         // Terminals float in the same cycle that the input opens
         hiz_reg      <= ~input_en_next;
         fault_reg    <= fault_next;
         busy_reg     <= (state_next == LCOM_MEAS);
         if (take_get && is_meas) begin
            msel_reg <= msel_new;
         end
      end
   end

   // Answer: immediate for Set and register Get, after a sample
   // for a measurement query
   wire reg_get = take_get && !is_meas;

   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         done_reg <= 1'b0;
         err_reg  <= 1'b0;
      end else begin
         done_reg <= 1'b0;
         err_reg  <= 1'b0;
         if (meas_done) begin
            done_reg <= 1'b1;
         end else if (take_set) begin
            done_reg <= 1'b1;
            err_reg  <= ~set_ok;
         end else if (reg_get) begin
            done_reg <= 1'b1;
            err_reg  <= ~get_ok;
         end
      end
   end

   // Read data stands until the next Get answer, so a slow host
   // can still collect it after the done pulse
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         rdata_reg <= FLOAT_ZERO_RST;
      end else if (meas_done) begin
         rdata_reg <= meas_data;
      end else if (reg_get) begin
         rdata_reg <= get_data;
      end
   end

   assign o_svc_done          = done_reg;
   assign o_svc_err           = err_reg;
   assign o_svc_rdata         = rdata_reg;
   assign o_svc_busy          = busy_reg;
   assign o_input_on          = input_en_reg;
   assign o_term_hiz          = hiz_reg;
   assign o_current_target    = curr_tgt_reg;
   assign o_voltage_target    = volt_tgt_reg;
   assign o_power_target      = pwr_tgt_reg;
   assign o_resistance_target = res_tgt_reg;
   assign o_trip_fault        = fault_reg;
endmodule : lcom_core
`default_nettype wire

// [sim/lcom_core_properties.sv]
// Concurrent checks on the command bank ports
`timescale 1ns/100ps
`default_nettype none
module lcom_props
   import lcom_pkg::*;
(
   input wire logic        i_ref_clk,        // Clock
   input wire logic        i_sys_rst,        // Reset
   input wire logic        i_svc_valid,      // Strobe
   input wire logic        i_svc_set,        // Set or Get
   input wire logic [15:0] i_svc_inst,       // Instance
   input wire logic [31:0] i_svc_wdata,      // Set value
   input wire logic        o_svc_done,       // Answer
   input wire logic        o_svc_err,        // Refusal
   input wire logic        o_svc_busy,       // Query wait
   input wire logic        i_meas_valid,     // Sample
   input wire logic        o_input_on,       // Input on
   input wire logic        o_term_hiz,       // High-Z
   input wire logic [31:0] o_current_target, // CC target
   input wire logic [31:0] o_voltage_target, // CV target
   input wire logic [3:0]  o_trip_fault      // Faults
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_sys_rst);
   wire take = i_svc_valid && !o_svc_busy;
   wire set_en = take && i_svc_set && i_svc_inst == INST_INPUT_EN;

   a_hiz_mirror: assert property (o_term_hiz == !o_input_on)
      else $error("high-Z not inverse of input on");
   a_set_answer: assert property (take && i_svc_set |=> o_svc_done)
      else $error("set not answered next cycle");
   a_curr_target: assert property (take && i_svc_set &&
      i_svc_inst == INST_CURR_TGT_WR |=> o_current_target == $past(i_svc_wdata))
      else $error("current target not written");
   a_volt_target: assert property (take && i_svc_set &&
      i_svc_inst == INST_VOLT_TGT_WR |=> o_voltage_target == $past(i_svc_wdata))
      else $error("voltage target not written");
   a_query_waits: assert property (take && !i_svc_set &&
      i_svc_inst == INST_MEAS_CURR |=> o_svc_busy && !o_svc_done)
      else $error("query answered before a sample");
   a_query_answer: assert property (o_svc_busy && i_meas_valid
      |=> o_svc_done && !o_svc_busy)
      else $error("query not answered after sample");
   a_trip_opens: assert property (
      |(o_trip_fault & ~$past(o_trip_fault)) |-> !o_input_on && o_term_hiz)
      else $error("trip without disconnect");
   a_off_frozen: assert property (!o_input_on && !set_en
      |=> $stable(o_trip_fault))
      else $error("trip faults moved while input off");
   a_err_in_done: assert property (o_svc_err |-> o_svc_done)
      else $error("refusal without answer");
endmodule : lcom_props
bind lcom_core lcom_props u_props (.i_ref_clk, .i_sys_rst, .i_svc_valid,
   .i_svc_set, .i_svc_inst, .i_svc_wdata, .o_svc_done, .o_svc_err,
   .o_svc_busy, .i_meas_valid, .o_input_on, .o_term_hiz, .o_current_target,
   .o_voltage_target, .o_trip_fault);
`default_nettype wire

// [sim/lcom_host.sv]
// Remote host model issuing Get and Set services
`timescale 1ns/100ps
`default_nettype none
module lcom_host (
   input  wire logic        i_ref_clk,   // Clock
   input  wire logic        i_svc_done,  // Answer
   input  wire logic        i_svc_err,   // Refusal
   input  wire logic [31:0] i_svc_rdata, // Get data
   output logic             o_svc_valid, // Strobe
   output logic             o_svc_set,   // Set or Get
   output logic [15:0]      o_svc_inst,  // Instance
   output logic [31:0]      o_svc_wdata  // Set value
);
   initial begin
      o_svc_valid = 1'h0;
      o_svc_set = 1'h0;
      o_svc_inst = 16'h0000;
      o_svc_wdata = 32'h0000_0000;
   end
   // One request in flight; a lost answer leaves unknowns behind
   task automatic xfer(input logic s, input logic [15:0] n,
         input logic [31:0] w, output logic [31:0] rd, output logic e);
      rd = 'x;
      e = 'x;
      @(posedge i_ref_clk);
      o_svc_valid <= 1'h1;
      o_svc_set <= s;
      o_svc_inst <= n;
      o_svc_wdata <= w;
      @(posedge i_ref_clk);
      o_svc_valid <= 1'h0;
      o_svc_wdata <= ~w;
      // A Set or register Get answers right after the taking edge and
      // the pulse lasts one cycle, so look before waiting again
      for (int k = 0; k < 64; k++) begin
         #1;
         if (i_svc_done === 1'h1) begin
            rd = i_svc_rdata;
            e = i_svc_err;
            break;
         end
         @(posedge i_ref_clk);
      end
   endtask : xfer
endmodule : lcom_host
`default_nettype wire

// [sim/load_command_object_map_tb.sv]
// Self-checking bench for the command bank
`timescale 1ns/100ps
`default_nettype none
module load_command_object_map_tb;
   import lcom_pkg::*;
   logic        i_ref_clk = 1'h0;
   logic        i_sys_rst = 1'h1;
   logic        sv, ss, done, err, busy, on, hiz;
   logic [15:0] si;
   logic [31:0] sw, rdata, tc, tv, tp, tr;
   logic        mv = 1'h0, sense = 1'h0;
   logic [31:0] mc = 32'h3F80_0001, mvo = 32'h3F80_0002;
   logic [31:0] ms = 32'h3F80_0003, mp = 32'h3F80_0004;
   logic [31:0] mr = 32'h3F80_0005;
   logic [8:0]  flt = 9'h000;
   logic [3:0]  trip;
   int          n_fail = 0, n_checks = 0;

   always #2.5 i_ref_clk = ~i_ref_clk;

   lcom_host u_host (.i_ref_clk(i_ref_clk), .i_svc_done(done),
      .i_svc_err(err), .i_svc_rdata(rdata), .o_svc_valid(sv),
      .o_svc_set(ss), .o_svc_inst(si), .o_svc_wdata(sw));
   lcom_core u_dut (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
      .i_svc_valid(sv), .i_svc_set(ss), .i_svc_inst(si), .i_svc_wdata(sw),
      .o_svc_done(done), .o_svc_err(err), .o_svc_rdata(rdata),
      .o_svc_busy(busy), .i_meas_valid(mv), .i_meas_current(mc),
      .i_meas_voltage(mvo), .i_meas_sense_volt(ms), .i_sense_engaged(sense),
      .i_meas_power(mp), .i_meas_resistance(mr),
      .i_missing_phase_flag(flt[0]), .i_input_fuse_open_flag(flt[1]),
      .i_fan_stall_flag(flt[2]), .i_power_module_overheat(flt[3]),
      .i_output_filter_overheat(flt[4]),
      .i_output_capacitor_overheat(flt[5]),
      .i_transformer_overheat(flt[6]), .i_bad_rating_flag(flt[7]),
      .i_firmware_mismatch_flag(flt[8]), .o_input_on(on),
      .o_term_hiz(hiz), .o_current_target(tc), .o_voltage_target(tv),
      .o_power_target(tp), .o_resistance_target(tr), .o_trip_fault(trip));

   task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic svc(input logic s, input logic [15:0] n,
         input logic [31:0] w, input logic ee, output logic [31:0] rd);
      logic e;
      u_host.xfer(s, n, w, rd, e);
      chk("svc err", 32'(e), 32'(ee));
   endtask : svc

   task automatic en(input logic b);
      logic [31:0] rd;
      svc(1'h1, INST_INPUT_EN, 32'(b), 1'h0, rd);
      chk("input on", 32'(on), 32'(b));
      chk("high-Z", 32'(hiz), 32'(!b));
   endtask : en

   task automatic t_targets;
      logic [15:0] wr[8];
      logic [31:0] rd, tg[4];
      wr = '{INST_CURR_TGT_WR, INST_VOLT_TGT_WR, INST_PWR_TGT_WR,
         INST_RES_TGT_WR, INST_CURR_TRIP_WR, INST_HV_TRIP_WR,
         INST_PWR_TRIP_WR, INST_LV_TRIP_WR};
      for (int i = 0; i < 8; i++) begin
         svc(1'h1, wr[i], 32'h4120_0000 + i, 1'h0, rd);
      end
      tg = '{tc, tv, tp, tr};
      for (int i = 0; i < 8; i++) begin
         if (i < 4) begin
            chk("target", tg[i], 32'h4120_0000 + i);
         end
         svc(1'h0, wr[i] + 16'h0001, 32'h0000_0000, 1'h0, rd);
         chk("readback", rd, 32'h4120_0000 + i);
         svc(1'h0, wr[i], 32'h0000_0000, 1'h1, rd);
         svc(1'h1, wr[i] + 16'h0001, 32'h0000_0000, 1'h1, rd);
      end
      svc(1'h0, 16'h0000, 32'h0000_0000, 1'h1, rd);
   endtask : t_targets

   task automatic t_status;
      int pos[9] = '{0, 1, 2, 4, 5, 6, 7, 16, 17};
      logic [31:0] rd;
      for (int i = 0; i <= 9; i++) begin
         @(posedge i_ref_clk);
         flt <= (i == 9) ? 9'h1FF : 9'h001 << i;
         repeat (4) @(posedge i_ref_clk);
         svc(1'h0, INST_STATUS1, 32'h0000_0000, 1'h0, rd);
         chk("status", rd, (i == 9) ? 32'h0003_00F7
            : 32'h1 << pos[i]);
      end
      svc(1'h1, INST_STATUS1, 32'hFFFF_FFFF, 1'h1, rd);
      svc(1'h0, INST_STATUS1, 32'h0000_0000, 1'h0, rd);
      chk("status again", rd, 32'h0003_00F7);
      flt <= 9'h000;
      repeat (4) @(posedge i_ref_clk);
      svc(1'h0, INST_STATUS1, 32'h0000_0000, 1'h0, rd);
      chk("status live", rd, 32'h0000_0000);
   endtask : t_status

   task automatic t_meas;
      logic [31:0] rd, ex[5];
      logic e;
      ex = '{32'h3F80_0001, 32'h3F80_0002, 32'h3F80_0004, 32'h3F80_0005,
         32'h3F80_0003};
      for (int j = 0; j < 5; j++) begin
         sense <= (j == 4);
         fork
            u_host.xfer(1'h0, (j == 4) ? INST_MEAS_VOLT
               : 16'(INST_MEAS_CURR + j), 32'h0000_0000, rd, e);
            begin
               repeat (5) @(posedge i_ref_clk);
               mv <= 1'h1;
               @(posedge i_ref_clk);
               mv <= 1'h0;
            end
         join
         chk("query", rd, ex[j]);
         chk("query err", 32'(e), 32'h0);
      end
   endtask : t_meas

   // Base samples sit between the limits; over makes source k break its limit
   task automatic sample(int k, bit over);
      @(posedge i_ref_clk);
      mv <= 1'h1;
      mc <= (over && k == 0) ? 32'h4080_0000 : 32'h3F80_0001;
      mvo <= !over ? 32'h3F80_0002 : (k == 1) ? 32'h4080_0000 :
         (k == 3) ? 32'h3E80_0000 : 32'h3F80_0002;
      mp <= (over && k == 2) ? 32'h4080_0000 : 32'h3F80_0004;
      @(posedge i_ref_clk);
      mv <= 1'h0;
   endtask : sample

   task automatic t_trip;
      logic [31:0] rd;
      svc(1'h1, INST_CURR_TRIP_WR, 32'h4000_0000, 1'h0, rd);
      svc(1'h1, INST_HV_TRIP_WR, 32'h4000_0000, 1'h0, rd);
      svc(1'h1, INST_PWR_TRIP_WR, 32'h4000_0000, 1'h0, rd);
      svc(1'h1, INST_LV_TRIP_WR, 32'h3F00_0000, 1'h0, rd);
      for (int k = 0; k < 4; k++) begin
         en(1'h1);
         chk("trip cleared", 32'(trip), 32'h0);
         repeat (3) sample(k, 1'b1);
         sample(k, 1'b0);
         repeat (3) sample(k, 1'b1);
         @(posedge i_ref_clk);
         #1;
         chk("no early trip", 32'(trip), 32'h0);
         sample(k, 1'b1);
         @(posedge i_ref_clk);
         #1;
         chk("trip", 32'(trip), 32'h1 << k);
         chk("opened", 32'(on), 32'h0);
      end
      en(1'h1);
      en(1'h0);
   endtask : t_trip

   task automatic summarize;
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : summarize

   initial begin
      repeat (5) @(posedge i_ref_clk);
      i_sys_rst <= 1'h0;
      #1;
      chk("reset high-Z", 32'(hiz), 32'h1);
      chk("reset target", tc, 32'h0000_0000);
      t_targets();
      t_status();
      t_meas();
      t_trip();
      summarize();
   end

   initial begin
      #60000;
      n_fail++;
      summarize();
   end
endmodule : load_command_object_map_tb
`default_nettype wire
